/* src/pvm_pkg.sv */
// Purpose: shared constants for the port v low pin priority mux
// Assumes: avalon-mm register slave with 32-bit data, word addressing
// Notes: offsets are word indices on the register bus
package pvm_pkg;
    localparam int PORT_W = 8;
    localparam int LOW_W = 4;
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_LATCH = 3'h0;
    localparam logic [2:0] OFS_READBACK = 3'h1;
    localparam logic [2:0] OFS_DIRECTION = 3'h2;
    localparam logic [2:0] OFS_OWNER = 3'h3;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
    localparam int OWNER_W = 3;
    // owner codes reported per low pin
    localparam logic [2:0] OWN_GPIO = 3'h0;
    localparam logic [2:0] OWN_MOTOR = 3'h1;
    localparam logic [2:0] OWN_TIMER = 3'h2;
    localparam logic [2:0] OWN_I2C = 3'h3;
    localparam logic [2:0] OWN_PWM = 3'h4;
    localparam logic [2:0] OWN_SPI = 3'h5;
    typedef enum logic [1:0] {
        PVM_IDLE = 2'b01,
        PVM_ANSWER = 2'b10
    } pvm_bus_e;
endpackage

/* src/pvm_port_v_mux.sv */
// Purpose: pin ownership and readback for the low four pins of port v
// Assumes: peripheral enables and outputs arrive on ref_clk; pins are asynchronous
// Notes: upper pins 7-4 act as plain gpio here; registers sit on avalon-mm
`timescale 1ns/1ns
// Function
// - data read: latch if output, else pin
// - unclaimed low pins are plain gpio
// - motor pwm beats every other function
// - pin 3: motor, i2c, pwm_channel_seven, spi, gpio
// - pin 2: motor, timer ch1, sck, pwm6, gpio
// - pin 1: motor, mosi, pwm5, gpio
// - pin 0: motor, timer ch0, scl, pwm4, miso
// - timer claims pin only when channel enabled
// - input register always returns all pin levels
// - motor pwm forces pin to output
module pvm_port_v_mux #(
    parameter int PORT_W = pvm_pkg::PORT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [pvm_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // peripheral requests; motor and pwm one bit per low pin, timer one enable per channel, i2c and spi shared enables
    input wire logic [3:0] motor_en,
    input wire logic [3:0] motor_out,
    input wire logic timer_ch0_en,
    input wire logic timer_ch0_out,
    input wire logic timer_ch1_en,
    input wire logic timer_ch1_out,
    input wire logic i2c_en,
    input wire logic i2c_scl_oe,
    input wire logic i2c_sda_oe,
    input wire logic [3:0] pwm_en,
    input wire logic [3:0] pwm_out,
    input wire logic spi_en,
    input wire logic spi_ss_oe,
    input wire logic spi_ss_out,
    input wire logic spi_sck_oe,
    input wire logic spi_sck_out,
    input wire logic spi_mosi_oe,
    input wire logic spi_mosi_out,
    input wire logic spi_miso_oe,
    input wire logic spi_miso_out,
    // peripheral input view
    output logic [3:0] periph_in,
    // pads
    input wire logic [PORT_W-1:0] pin_in,
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe
);
    logic [PORT_W-1:0] port_v_output_latch;
    logic [PORT_W-1:0] port_v_direction;
    logic [PORT_W-1:0] pin_sync;
    pvm_pkg::pvm_bus_e bus_state;
    pvm_pkg::pvm_bus_e next_bus_state;
    logic [3:0][pvm_pkg::OWNER_W-1:0] owner;
    logic [3:0] alt_out;
    logic [3:0] alt_oe;
    logic [PORT_W-1:0] data_view;
    logic [PORT_W-1:0] next_pin_out;
    logic [PORT_W-1:0] next_pin_oe;
    logic [31:0] next_readdata;
    wire sel_latch;
    wire sel_readback;
    wire sel_direction;
    wire sel_owner;
    wire wr_go;
    wire rd_go;

    // byte merge used by both writable registers
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] be);
        merge_byte = be[0] ? wd[7:0] : old_v;
    endfunction

    pvm_sync #(
        .WIDTH(PORT_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // pin 3 priority
    always_comb begin
        if (motor_en[3]) begin
            owner[3] = pvm_pkg::OWN_MOTOR;
            alt_out[3] = motor_out[3];
            alt_oe[3] = 1'b1;
        end else if (i2c_en) begin
            owner[3] = pvm_pkg::OWN_I2C;
            alt_out[3] = 1'b0; // open drain
            alt_oe[3] = i2c_sda_oe;
        end else if (pwm_en[3]) begin
            owner[3] = pvm_pkg::OWN_PWM;
            alt_out[3] = pwm_out[3];
            alt_oe[3] = 1'b1;
        end else if (spi_en) begin
            owner[3] = pvm_pkg::OWN_SPI;
            alt_out[3] = spi_ss_out;
            alt_oe[3] = spi_ss_oe;
        end else begin
            owner[3] = pvm_pkg::OWN_GPIO;
            alt_out[3] = port_v_output_latch[3];
            alt_oe[3] = port_v_direction[3];
        end
    end

    // pin 2 priority
    always_comb begin
        if (motor_en[2]) begin
            owner[2] = pvm_pkg::OWN_MOTOR;
            alt_out[2] = motor_out[2];
            alt_oe[2] = 1'b1;
        end else if (timer_ch1_en) begin
            owner[2] = pvm_pkg::OWN_TIMER;
            alt_out[2] = timer_ch1_out;
            alt_oe[2] = 1'b1;
        end else if (spi_en) begin
            owner[2] = pvm_pkg::OWN_SPI;
            alt_out[2] = spi_sck_out;
            alt_oe[2] = spi_sck_oe;
        end else if (pwm_en[2]) begin
            owner[2] = pvm_pkg::OWN_PWM;
            alt_out[2] = pwm_out[2];
            alt_oe[2] = 1'b1;
        end else begin
            owner[2] = pvm_pkg::OWN_GPIO;
            alt_out[2] = port_v_output_latch[2];
            alt_oe[2] = port_v_direction[2];
        end
    end

    // pin 1 priority
    always_comb begin
        if (motor_en[1]) begin
            owner[1] = pvm_pkg::OWN_MOTOR;
            alt_out[1] = motor_out[1];
            alt_oe[1] = 1'b1;
        end else if (spi_en) begin
            owner[1] = pvm_pkg::OWN_SPI;
            alt_out[1] = spi_mosi_out;
            alt_oe[1] = spi_mosi_oe;
        end else if (pwm_en[1]) begin
            owner[1] = pvm_pkg::OWN_PWM;
            alt_out[1] = pwm_out[1];
            alt_oe[1] = 1'b1;
        end else begin
            owner[1] = pvm_pkg::OWN_GPIO;
            alt_out[1] = port_v_output_latch[1];
            alt_oe[1] = port_v_direction[1];
        end
    end

    // pin 0 priority
    always_comb begin
        if (motor_en[0]) begin
            owner[0] = pvm_pkg::OWN_MOTOR;
            alt_out[0] = motor_out[0];
            alt_oe[0] = 1'b1;
        end else if (timer_ch0_en) begin
            owner[0] = pvm_pkg::OWN_TIMER;
            alt_out[0] = timer_ch0_out;
            alt_oe[0] = 1'b1;
        end else if (i2c_en) begin
            owner[0] = pvm_pkg::OWN_I2C;
            alt_out[0] = 1'b0; // open drain
            alt_oe[0] = i2c_scl_oe;
        end else if (pwm_en[0]) begin
            owner[0] = pvm_pkg::OWN_PWM;
            alt_out[0] = pwm_out[0];
            alt_oe[0] = 1'b1;
        end else if (spi_en) begin
            owner[0] = pvm_pkg::OWN_SPI;
            alt_out[0] = spi_miso_out;
            alt_oe[0] = spi_miso_oe;
        end else begin
            owner[0] = pvm_pkg::OWN_GPIO;
            alt_out[0] = port_v_output_latch[0];
            alt_oe[0] = port_v_direction[0];
        end
    end

    // pad drive: low pins from the mux, upper pins plain gpio
    assign next_pin_out = {port_v_output_latch[PORT_W-1:pvm_pkg::LOW_W], alt_out};
    assign next_pin_oe = {port_v_direction[PORT_W-1:pvm_pkg::LOW_W], alt_oe};

    // pin levels seen by peripherals
    assign periph_in = pin_sync[pvm_pkg::LOW_W-1:0];

    // data register view per direction bit
    assign data_view = (port_v_direction & port_v_output_latch) | (~port_v_direction & pin_sync);

    // bus decode
    assign sel_latch = (avs_address == pvm_pkg::OFS_LATCH);
    assign sel_readback = (avs_address == pvm_pkg::OFS_READBACK);
    assign sel_direction = (avs_address == pvm_pkg::OFS_DIRECTION);
    assign sel_owner = (avs_address == pvm_pkg::OFS_OWNER);
    // write lands at the edge where waitrequest is low
    assign wr_go = avs_write && (bus_state == pvm_pkg::PVM_ANSWER);
    assign rd_go = avs_read && (bus_state == pvm_pkg::PVM_IDLE);
    assign avs_waitrequest = (avs_read || avs_write) && (bus_state == pvm_pkg::PVM_IDLE);

    // read mux
    always_comb begin
        next_readdata = pvm_pkg::UNMAPPED_DATA;
        if (sel_latch) begin
            next_readdata[PORT_W-1:0] = data_view;
        end else if (sel_readback) begin
            next_readdata[PORT_W-1:0] = pin_sync;
        end else if (sel_direction) begin
            next_readdata[PORT_W-1:0] = port_v_direction;
        end else if (sel_owner) begin
            next_readdata[4*pvm_pkg::OWNER_W-1:0] = owner;
        end
    end

    // bus state: one wait cycle, answer in the next
    always_comb begin
        case (bus_state)
            pvm_pkg::PVM_IDLE: next_bus_state = (avs_read || avs_write) ? pvm_pkg::PVM_ANSWER : pvm_pkg::PVM_IDLE;
            pvm_pkg::PVM_ANSWER: next_bus_state = pvm_pkg::PVM_IDLE;
            default: next_bus_state = pvm_pkg::PVM_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bus_state <= pvm_pkg::PVM_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    // registers: latch written regardless of pin owner
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            port_v_output_latch <= pvm_pkg::LATCH_RST;
            port_v_direction <= pvm_pkg::DIR_RST;
        end else if (wr_go && sel_latch) begin
            port_v_output_latch <= merge_byte(port_v_output_latch, avs_writedata, avs_byteenable);
        end else if (wr_go && sel_direction) begin
            port_v_direction <= merge_byte(port_v_direction, avs_writedata, avs_byteenable);
        end
    end

    // read data and pad registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_readdata <= pvm_pkg::UNMAPPED_DATA;
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            if (rd_go) begin
                avs_readdata <= next_readdata;
            end
            pin_out <= next_pin_out;
            pin_oe <= next_pin_oe;
        end
    end
endmodule

/* src/pvm_sync.sv */
// Purpose: two-flop synchroniser for the port pin levels
// Assumes: pins are asynchronous to ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module pvm_sync #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // two stage capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule

/* testbench/port_v_low_pin_priority_mux_tb_top.sv */
// Purpose: self-checking bench for the port v low pin mux
// Assumes: 50 MHz ref_clk, avalon-mm slave with one wait state
// Notes: peripheral enables are stepped down a priority table
`timescale 1ns/1ns
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module port_v_low_pin_priority_mux_tb_top;
    localparam logic [2:0] g = pvm_pkg::OWN_GPIO, m = pvm_pkg::OWN_MOTOR, t = pvm_pkg::OWN_TIMER;
    localparam logic [2:0] c = pvm_pkg::OWN_I2C, w = pvm_pkg::OWN_PWM, s = pvm_pkg::OWN_SPI;
    // owners pin3..pin0 per step; enables are motor, timer, i2c, pwm, spi
    localparam logic [11:0] own_tab [7] = '{{m, m, m, m}, {c, t, s, t}, {c, s, s, c}, {w, s, s, w},
        {w, w, w, w}, {s, s, s, s}, {g, g, g, g}};
    localparam logic [4:0] en_tab [7] = '{5'h1F, 5'h0F, 5'h07, 5'h03, 5'h02, 5'h01, 5'h00};
    logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [2:0] avs_address = 3'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [4:0] en = 5'h00;
    logic [19:0] outs = 20'h5A5A5;
    logic [7:0] pin_in, pin_out, pin_oe, ext_level = 8'hC3, short_mask = 8'h00;
    logic [3:0] periph_in;
    wire [3:0] motor_en, motor_out, pwm_en, pwm_out;
    wire timer_ch0_en, timer_ch0_out, timer_ch1_en, timer_ch1_out, i2c_en, i2c_scl_oe, i2c_sda_oe;
    wire spi_en, spi_ss_oe, spi_ss_out, spi_sck_oe, spi_sck_out, spi_mosi_oe, spi_mosi_out;
    wire spi_miso_oe, spi_miso_out;
    int n_fail = 0, comparisons = 0, cycles = 0;
    // fan the packed stimulus out to the peripheral ports
    assign {motor_en, timer_ch0_en, timer_ch1_en, i2c_en, pwm_en, spi_en} =
        {{4{en[4]}}, {2{en[3]}}, en[2], {4{en[1]}}, en[0]};
    assign {motor_out, pwm_out, timer_ch0_out, timer_ch1_out, i2c_scl_oe, i2c_sda_oe, spi_ss_oe,
        spi_ss_out, spi_sck_oe, spi_sck_out, spi_mosi_oe, spi_mosi_out, spi_miso_oe, spi_miso_out} = outs;
    pvm_port_v_mux DUT (.*);
    pvm_pad_model pads (.*);
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // cycle ceiling against a hung handshake
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_fail++;
            final_report();
        end
    end
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic t_reset();
        rst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        `CHK(pin_oe, 8'h00)
        bus(1'b0, pvm_pkg::OFS_DIRECTION, 32'h0);
        `CHK(rd[7:0], pvm_pkg::DIR_RST)
        bus(1'b0, pvm_pkg::OFS_LATCH, 32'h0);
        `CHK(rd, {24'h0, ext_level})
        // all outputs off: capture path sees the board level
        `CHK(periph_in, ext_level[3:0])
    endtask
    task automatic t_priority();
        for (int i = 0; i < 7; i++) begin
            en <= en_tab[i];
            outs <= {outs[18:0], ~outs[19]};
            repeat (2) @(posedge ref_clk);
            if (i == 0) begin
                `CHK({pin_oe[3:0], pin_out[3:0]}, {4'hF, motor_out})
                bus(1'b1, pvm_pkg::OFS_LATCH, 32'h0B);
            end
            bus(1'b0, pvm_pkg::OFS_OWNER, 32'h0);
            `CHK(rd[11:0], own_tab[i])
        end
    endtask
    task automatic t_gpio();
        bus(1'b1, pvm_pkg::OFS_DIRECTION, 32'h0F);
        repeat (2) @(posedge ref_clk);
        `CHK({pin_oe, pin_out[3:0]}, 12'h0FB)
        bus(1'b1, pvm_pkg::OFS_LATCH, 32'hA4);
        short_mask <= 8'h01;
        repeat (4) @(posedge ref_clk);
        `CHK({pin_oe, pin_out[3:0]}, 12'h0F4)
        bus(1'b0, pvm_pkg::OFS_LATCH, 32'h0);
        `CHK(rd, 32'h000000C4)
        bus(1'b0, pvm_pkg::OFS_READBACK, 32'h0);
        `CHK(rd, 32'h000000C5)
        bus(1'b1, 3'h5, 32'hFF);
        bus(1'b0, 3'h5, 32'h0);
        `CHK(rd, pvm_pkg::UNMAPPED_DATA)
        // masked byte lane leaves the latch alone
        avs_byteenable <= 4'hE;
        bus(1'b1, pvm_pkg::OFS_LATCH, 32'h5B);
        avs_byteenable <= 4'hF;
        bus(1'b0, pvm_pkg::OFS_LATCH, 32'h0);
        `CHK(rd, 32'h000000C4)
        short_mask <= 8'h00;
    endtask
    task automatic final_report();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        t_reset();
        t_priority();
        t_gpio();
        t_reset();
        final_report();
    end
endmodule

/* testbench/pvm_pad_model.sv */
// Purpose: pad model for the port v pins
// Assumes: ext_level is the board level seen on undriven pins
// Notes: short_mask overrides a driven level, as a shorted pin would
`timescale 1ns/1ns
module pvm_pad_model #(
    parameter int PORT_W = 8
) (
    input wire logic [PORT_W-1:0] pin_out,
    input wire logic [PORT_W-1:0] pin_oe,
    input wire logic [PORT_W-1:0] ext_level,
    input wire logic [PORT_W-1:0] short_mask,
    output logic [PORT_W-1:0] pin_in
);
    // driven pins show their driver unless shorted, others the board level
    wire [PORT_W-1:0] own = pin_oe & ~short_mask;
    assign pin_in = (own & pin_out) | (~own & ext_level);
endmodule

/* testbench/pvm_port_v_mux_sva.sv */
// Purpose: checks on pin ownership and bus wait timing
// Assumes: one clock, synchronous reset
// Notes: bound to the mux top
`timescale 1ns/1ns
module pvm_port_v_mux_sva #(
    parameter int PORT_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic [3:0] motor_en,
    input wire logic [3:0] motor_out,
    input wire logic timer_ch0_en,
    input wire logic timer_ch0_out,
    input wire logic timer_ch1_en,
    input wire logic timer_ch1_out,
    input wire logic i2c_en,
    input wire logic i2c_scl_oe,
    input wire logic i2c_sda_oe,
    input wire logic [3:0] pwm_en,
    input wire logic [3:0] pwm_out,
    input wire logic spi_en,
    input wire logic spi_mosi_oe,
    input wire logic spi_mosi_out,
    input wire logic [PORT_W-1:0] pin_out,
    input wire logic [PORT_W-1:0] pin_oe
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    // owner of each pin shows one cycle after its request
    motor_wins_a: assert property (|motor_en |=> ((pin_oe[3:0] & $past(motor_en)) == $past(motor_en))
        && (((pin_out[3:0] ^ $past(motor_out)) & $past(motor_en)) == 4'h0)) else $error("motor pin wrong");
    timer_pin0_a: assert property (!motor_en[0] && timer_ch0_en |=> pin_oe[0]
        && pin_out[0] == $past(timer_ch0_out)) else $error("timer pin 0 wrong");
    timer_pin2_a: assert property (!motor_en[2] && timer_ch1_en |=> pin_oe[2]
        && pin_out[2] == $past(timer_ch1_out)) else $error("timer pin 2 wrong");
    sda_pin3_a: assert property (!motor_en[3] && i2c_en |=> !pin_out[3]
        && pin_oe[3] == $past(i2c_sda_oe)) else $error("data line pin 3 wrong");
    scl_pin0_a: assert property (!motor_en[0] && !timer_ch0_en && i2c_en |=> !pin_out[0]
        && pin_oe[0] == $past(i2c_scl_oe)) else $error("clock line pin 0 wrong");
    mosi_pin1_a: assert property (!motor_en[1] && spi_en |=> pin_oe[1] == $past(spi_mosi_oe)
        && (!pin_oe[1] || pin_out[1] == $past(spi_mosi_out))) else $error("mosi pin 1 wrong");
    pwm_pin3_a: assert property (!motor_en[3] && !i2c_en && pwm_en[3] |=> pin_oe[3]
        && pin_out[3] == $past(pwm_out[3])) else $error("pwm pin 3 wrong");
    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    cover property (|motor_en);
    cover property (timer_ch1_en && !motor_en[2]);
    cover property (avs_read && !avs_waitrequest);
endmodule
bind pvm_port_v_mux pvm_port_v_mux_sva #(.PORT_W(PORT_W)) chk (.*);
